// ===== hdl/fsps_sequencer.sv
// flash self-programming sequencer with classic wishbone register slave
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
module fsps_sequencer #(
    parameter int PAGE_WORD_BITS = 6, // words per page = 2**PAGE_WORD_BITS
    parameter int HALTING_WRITE_SECTION_FIRST_PAGE = 96 // first page of the halting_write_section
) (
    input wire logic ref_clk_i, // 250 mhz system clock
    input wire logic reset_i, // synchronous, active high
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // eeprom controller status, same clock
    input wire logic eeprom_write_busy_i,
    // flash array
    output fsps_pkg::fsps_op_t flash_op_o,
    output logic flash_start_o,
    output logic [15-PAGE_WORD_BITS-1:0] flash_page_o,
    output logic [fsps_pkg::FSPS_LOCK_W-1:0] flash_lock_o,
    input wire logic flash_done_i,
    input wire logic [PAGE_WORD_BITS-1:0] buf_raddr_i,
    output logic [15:0] buf_rdata_o,
    input wire logic [15:0] flash_rword_i,
    // core side status
    output logic halt_o,
    output logic rww_read_block_o,
    output logic irq_o
);
    import fsps_pkg::*;

    localparam int WORDS = 1 << PAGE_WORD_BITS;
    localparam int PAGE_W = 15 - PAGE_WORD_BITS;

    // ****************************************************************
    // state
    // ****************************************************************
    fsps_state_t state_q, state_d; // sequencer state
    logic [7:0] ctrl_q; // control bits as written
    logic busy_q; // section_busy_bit
    logic [15:0] ptr_q; // address pointer
    logic [15:0] data_q; // data_high_reg:data_low_reg
    localparam int LOCK_W_L = FSPS_LOCK_W;
    logic [LOCK_W_L-1:0] lock_q; // stored lock bits
    logic [2:0] win_q; // store window counter
    logic [PAGE_W-1:0] page_q; // latched page
    logic halting_write_section_q; // latched section is halting
    fsps_op_t op_q; // running operation
    logic [LOCK_W_L-1:0] lock_new_q; // lock value being programmed
    logic [15:0] buf_mem [WORDS]; // temporary page buffer
    logic [WORDS-1:0] buf_vld_q; // word loaded flags
    logic ack_q; // wishbone ack
    logic [31:0] rdat_q; // read data
    logic start_q; // flash start pulse

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire req = wb_cyc_i && wb_stb_i && !ack_q;
    wire wr = req && wb_we_i;
    wire wr_ctrl = wr && (wb_adr_i == FSPS_OFS_CTRL) && wb_sel_i[0];
    wire wr_ptr_lo = wr && (wb_adr_i == FSPS_OFS_PTR) && wb_sel_i[0];
    wire wr_ptr_hi = wr && (wb_adr_i == FSPS_OFS_PTR) && wb_sel_i[1];
    wire wr_dat_lo = wr && (wb_adr_i == FSPS_OFS_DATA) && wb_sel_i[0];
    wire wr_dat_hi = wr && (wb_adr_i == FSPS_OFS_DATA) && wb_sel_i[1];
    wire store = wr && (wb_adr_i == FSPS_OFS_STORE);
    wire [5:0] cmd_bits = ctrl_q[5:0] & FSPS_CMD_MASK;
    wire is_idle = (state_q == FSPS_ST_IDLE);

    // pointer split: word in page and page select
    wire [PAGE_WORD_BITS-1:0] word_in_page_field = ptr_q[PAGE_WORD_BITS:1]; // RQ1
    wire [PAGE_W-1:0] page_select_field = ptr_q[15:PAGE_WORD_BITS+1]; // RQ1
    wire page_is_halting_write_section = ({1'b0, page_select_field} >= (PAGE_W+1)'(HALTING_WRITE_SECTION_FIRST_PAGE));

    // a command write needs the enable bit and no eeprom write in progress
    wire cmd_wr = wr_ctrl && wb_dat_i[FSPS_B_ENABLE] && !wb_dat_i[FSPS_B_REEN]
                  && !eeprom_write_busy_i && is_idle; // RQ19
    // re-enable write clears busy and buffer once nothing runs
    wire reen_wr = wr_ctrl && wb_dat_i[FSPS_B_REEN] && (state_q != FSPS_ST_RUN); // RQ15

    // store taken while the window is still open
    wire store_ok = store && (state_q == FSPS_ST_ARMED) && (win_q != 3'h0)
                    && !eeprom_write_busy_i; // RQ5 RQ7 RQ11 RQ16 RQ19
    wire do_erase = store_ok && (cmd_bits == FSPS_CMD_ERASE); // RQ5
    wire do_load = store_ok && (cmd_bits == FSPS_CMD_LOAD); // RQ7
    wire do_write = store_ok && (cmd_bits == FSPS_CMD_WRITE); // RQ11
    wire do_lock = store_ok && (cmd_bits == FSPS_CMD_LOCK); // RQ16
    wire do_flash = do_erase || do_write || do_lock;
    wire win_expired = (state_q == FSPS_ST_ARMED) && (win_q == 3'h0) && !store_ok; // RQ24
    wire op_done = (state_q == FSPS_ST_RUN) && flash_done_i;

    // a store in the window with an unknown pattern just closes the window
    wire store_void = store_ok && !do_erase && !do_load && !do_write && !do_lock;

    // ****************************************************************
    // sequencer state machine
    // ****************************************************************
    // next state: armed by a command write, run by a flash store
    always_comb begin
        state_d = state_q;
        case (state_q)
            FSPS_ST_IDLE: begin
                if (cmd_wr) begin
                    state_d = FSPS_ST_ARMED;
                end
            end
            FSPS_ST_ARMED: begin
                if (do_flash) begin
                    state_d = FSPS_ST_RUN;
                end else if (do_load || store_void || win_expired) begin
                    state_d = FSPS_ST_IDLE; // RQ24
                end
            end
            FSPS_ST_RUN: begin
                if (flash_done_i) begin
                    state_d = FSPS_ST_IDLE;
                end
            end
            default: begin
                state_d = FSPS_ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_q <= FSPS_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // store window: loaded on the command write, counts down until it reaches zero, whatever the state
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            win_q <= 3'h0;
        end else if (cmd_wr) begin
            win_q <= FSPS_STORE_WINDOW; // RQ5
        end else if (win_q != 3'h0) begin
            win_q <= win_q - 3'h1;
        end
    end

    // ****************************************************************
    // control and status
    // ****************************************************************
    // command bits self-clear on completion, on a load, or on window expiry;
    // the interrupt enable is kept separately so software can leave it set
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ctrl_q <= 8'h00;
        end else if (cmd_wr) begin
            ctrl_q <= {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
        end else if (wr_ctrl && is_idle) begin
            ctrl_q <= {wb_dat_i[7], 7'h00}; // only the enable of the interrupt sticks
        end else if (op_done || do_load || store_void || win_expired) begin
            ctrl_q <= {ctrl_q[FSPS_B_IRQEN], 7'h00}; // RQ24
        end
    end

    // section busy: set on rww erase/write, cleared only by a re-enable write;
    // a new operation starting in the same cycle wins over the clear
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            busy_q <= 1'b0;
        end else if ((do_erase || do_write) && !page_is_halting_write_section) begin
            busy_q <= 1'b1; // RQ14
        end else if (reen_wr) begin
            busy_q <= 1'b0; // RQ15
        end
    end

    // ****************************************************************
    // pointer and data registers
    // ****************************************************************
    // plain storage; a running operation reads only the latched copy
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ptr_q <= 16'h0000;
            data_q <= 16'h0000;
        end else begin
            if (wr_ptr_lo) begin
                ptr_q[7:0] <= wb_dat_i[7:0];
            end
            if (wr_ptr_hi) begin
                ptr_q[15:8] <= wb_dat_i[15:8];
            end
            if (wr_dat_lo) begin
                data_q[7:0] <= wb_dat_i[7:0];
            end
            if (wr_dat_hi) begin
                data_q[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // ****************************************************************
    // operation latch and flash array handoff
    // ****************************************************************
    // page and section latched at the store so the pointer is free afterwards
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            page_q <= '0;
            halting_write_section_q <= 1'b0;
            op_q <= FSPS_OP_ERASE;
            lock_new_q <= FSPS_LOCK_RST;
            start_q <= 1'b0;
        end else begin
            start_q <= do_flash;
            if (do_erase || do_write) begin
                page_q <= page_select_field; // RQ2
                halting_write_section_q <= page_is_halting_write_section; // RQ2
                op_q <= do_erase ? FSPS_OP_ERASE : FSPS_OP_WRITE;
            end else if (do_lock) begin
                halting_write_section_q <= 1'b0; // RQ3 RQ18
                op_q <= FSPS_OP_LOCK;
                // a zero data bit programs the lock bit; programmed bits stay programmed
                lock_new_q <= lock_q & data_q[LOCK_W_L-1:0]; // RQ17 RQ23
            end
        end
    end

    // lock bits take their new value once the array reports done
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            lock_q <= FSPS_LOCK_RST; // RQ23
        end else if (op_done && (op_q == FSPS_OP_LOCK)) begin
            lock_q <= lock_new_q; // RQ17
        end
    end

    // ****************************************************************
    // temporary page buffer
    // ****************************************************************
    // clear on completed write, on re-enable, or when an eeprom write hits a load
    wire buf_clear = (op_done && (op_q == FSPS_OP_WRITE)) || reen_wr
                     || (eeprom_write_busy_i && (buf_vld_q != '0)); // RQ8 RQ10

    // valid flags; a second load of a word is dropped, the first stays
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            buf_vld_q <= '0; // RQ8
        end else if (buf_clear) begin
            buf_vld_q <= '0; // RQ8 RQ10
        end else if (do_load) begin
            buf_vld_q[word_in_page_field] <= 1'b1; // RQ22
        end
    end

    // storage, any order of words; erased words read as all ones
    always_ff @(posedge ref_clk_i) begin
        if (do_load && !buf_vld_q[word_in_page_field]) begin
            buf_mem[word_in_page_field] <= data_q; // RQ7 RQ22
        end
    end

    // read port for the array during a page write
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            buf_rdata_o <= 16'hffff;
        end else if (buf_vld_q[buf_raddr_i]) begin
            buf_rdata_o <= buf_mem[buf_raddr_i];
        end else begin
            buf_rdata_o <= 16'hffff;
        end
    end

    // ****************************************************************
    // core side outputs
    // ****************************************************************
    // halting section programming stops the core; lock programming never does
    assign halt_o = (state_q == FSPS_ST_RUN) && halting_write_section_q && (op_q != FSPS_OP_LOCK); // RQ6 RQ12 RQ18
    assign rww_read_block_o = busy_q; // RQ14
    // level interrupt, so the core may use it instead of polling
    assign irq_o = ctrl_q[FSPS_B_IRQEN] && !ctrl_q[FSPS_B_ENABLE]; // RQ13
    assign flash_op_o = op_q;
    assign flash_start_o = start_q;
    assign flash_page_o = page_q;
    assign flash_lock_o = lock_new_q;

    // ****************************************************************
    // wishbone read mux and ack
    // ****************************************************************
    // load byte: bit 0 of the pointer picks the byte of the fetched word
    wire [7:0] load_byte = ptr_q[0] ? flash_rword_i[15:8] : flash_rword_i[7:0]; // RQ4
    wire [7:0] ctrl_rd = {ctrl_q[FSPS_B_IRQEN], busy_q, ctrl_q[5:0]};
    // lock readback is blocked while the eeprom writes
    wire [7:0] lock_rd = eeprom_write_busy_i ? 8'h00 : {FSPS_LOCK_PAD, lock_q}; // RQ19

    wire [31:0] rd_mux = (wb_adr_i == FSPS_OFS_CTRL) ? {24'h000000, ctrl_rd} :
                         (wb_adr_i == FSPS_OFS_PTR) ? {16'h0000, ptr_q} :
                         (wb_adr_i == FSPS_OFS_DATA) ? {16'h0000, data_q} :
                         (wb_adr_i == FSPS_OFS_LOCK) ? {24'h000000, lock_rd} :
                         (wb_adr_i == FSPS_OFS_LOAD) ? {24'h000000, load_byte} :
                         32'h00000000;

    // one wait state: ack the cycle after the request, drop it after one cycle
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= req;
            if (req && !wb_we_i) begin
                rdat_q <= rd_mux;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

endmodule : fsps_sequencer

// ===== shared/fsps_pkg.sv
// constants, encodings and register map of the flash self-programming sequencer
// ****************************************************************
// Contract
// [RQ1] flash address comes from 16-bit pointer register
// [RQ2] address latched when a programming operation starts
// [RQ3] lock programming ignores the pointer completely
// [RQ4] load reads pick byte by pointer bit 0
// [RQ5] erase pattern plus store within four cycles
// [RQ6] halting-section erase halts core, other section readable
// [RQ7] load pattern stores data word at word field
// [RQ8] buffer clears after write, re-enable, reset
// [RQ9] software loads each buffer word only once
// [RQ10] eeprom write during loading discards loaded data
// [RQ11] write pattern plus store within four cycles
// [RQ12] halting-section write halts core, other section readable
// [RQ13] enabled interrupt stands while enable bit clear
// [RQ14] erase/write blocks section reads, busy bit set
// [RQ15] busy bit clears only by re-enable write
// [RQ16] lock pattern plus store within four cycles
// [RQ17] zero data bits 5..0 program lock bits
// [RQ18] lock programming keeps whole flash readable
// [RQ19] eeprom write blocks programming and lock reads
// [RQ20] software checks eeprom busy before control write
// [RQ21] software uses pointer 0x0001, data bits 7:6 one
// [RQ22] buffer accepts word loads in any order
// [RQ23] lock bit one unprogrammed, zero programmed
// [RQ24] no store in window clears pending command
// ****************************************************************
package fsps_pkg;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] FSPS_OFS_CTRL = 8'h00; // selfprog_ctrl_status_reg
    localparam logic [7:0] FSPS_OFS_PTR = 8'h04; // 16-bit address pointer
    localparam logic [7:0] FSPS_OFS_DATA = 8'h08; // data_low_reg in [7:0], data_high_reg in [15:8]
    localparam logic [7:0] FSPS_OFS_LOCK = 8'h0c; // lock bit readback
    localparam logic [7:0] FSPS_OFS_STORE = 8'h10; // store-program instruction strobe
    localparam logic [7:0] FSPS_OFS_LOAD = 8'h14; // program_load_instr byte readback

    // ****************************************************************
    // control register bit positions
    // ****************************************************************
    localparam int FSPS_B_ENABLE = 0; // selfprog_enable_bit
    localparam int FSPS_B_ERASE = 1; // page erase
    localparam int FSPS_B_WRITE = 2; // page write
    localparam int FSPS_B_LOCKSET = 3; // lock_set_bit
    localparam int FSPS_B_REEN = 4; // section_reenable_bit
    localparam int FSPS_B_BUSY = 6; // section_busy_bit, read only
    localparam int FSPS_B_IRQEN = 7; // completion interrupt enable

    // command patterns on control bits 5..0
    localparam logic [5:0] FSPS_CMD_MASK = 6'h3f;
    localparam logic [5:0] FSPS_CMD_ERASE = 6'h03;
    localparam logic [5:0] FSPS_CMD_LOAD = 6'h01;
    localparam logic [5:0] FSPS_CMD_WRITE = 6'h05;
    localparam logic [5:0] FSPS_CMD_LOCK = 6'h09;

    // ****************************************************************
    // lock bits and timing
    // ****************************************************************
    localparam int FSPS_LOCK_W = 6; // data bits 5..0
    localparam logic [5:0] FSPS_LOCK_RST = 6'h3f; // all unprogrammed
    localparam logic [1:0] FSPS_LOCK_PAD = 2'h3; // bits 7:6 read as one
    localparam logic [2:0] FSPS_STORE_WINDOW = 3'h4; // cycles after control write

    // flash array operation codes
    typedef enum logic [1:0] {
        FSPS_OP_ERASE = 2'h0,
        FSPS_OP_WRITE = 2'h1,
        FSPS_OP_LOCK = 2'h2
    } fsps_op_t;

    // sequencer states, gray along idle -> armed -> run
    typedef enum logic [1:0] {
        FSPS_ST_IDLE = 2'b00,
        FSPS_ST_ARMED = 2'b01,
        FSPS_ST_RUN = 2'b11
    } fsps_state_t;

endpackage : fsps_pkg

// ===== testbench/fsps_flash_model.sv
// behavioural flash array answering start with a done pulse
`timescale 1ns/1ns
module fsps_flash_model #(
    parameter logic [15:0] WORD = 16'ha55a // word seen at the pointer
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic flash_start_i,
    input wire logic slow_i, // long operation so the bench can look inside it
    output logic flash_done_o,
    output logic [15:0] flash_rword_o
);
    logic [5:0] cnt_q; // cycles left
    logic run_q; // operation in progress
    assign flash_rword_o = WORD;
    // ****
    // start loads the count, done pulses when it runs out
    // ****
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            run_q <= 1'b0;
            cnt_q <= 6'h00;
            flash_done_o <= 1'b0;
        end else begin
            flash_done_o <= run_q && cnt_q == 6'h01;
            if (flash_start_i) begin
                run_q <= 1'b1;
                cnt_q <= slow_i ? 6'h14 : 6'h02;
            end else if (run_q) begin
                cnt_q <= cnt_q - 6'h01;
                run_q <= cnt_q != 6'h01;
            end
        end
    end
endmodule : fsps_flash_model

// ===== testbench/fsps_sequencer_assertions.sv
// port relation checker of the flash self-programming sequencer
`timescale 1ns/1ns
module fsps_sequencer_assertions
import fsps_pkg::*;
#(
    parameter int PAGE_WORD_BITS = 6,
    parameter int HALTING_WRITE_SECTION_FIRST_PAGE = 96
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic eeprom_write_busy_i,
    input wire fsps_op_t flash_op_o,
    input wire logic flash_start_o,
    input wire logic [15-PAGE_WORD_BITS-1:0] flash_page_o,
    input wire logic [FSPS_LOCK_W-1:0] flash_lock_o,
    input wire logic halt_o,
    input wire logic rww_read_block_o,
    input wire logic irq_o
);
    // ****
    // one clock domain, reset clears every relation
    // ****
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    wire run_halting = flash_op_o != FSPS_OP_LOCK && flash_page_o >= HALTING_WRITE_SECTION_FIRST_PAGE; // halting page op

    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
    property p_start; flash_start_o |=> !flash_start_o; endproperty
    a_start: assert property (p_start) else $error("start longer than one cycle");
    property p_halt; halt_o |-> run_halting; endproperty
    a_halt: assert property (p_halt) else $error("halt outside halting section op");
    property p_halt_start; flash_start_o && run_halting |-> halt_o; endproperty
    a_halt_start: assert property (p_halt_start) else $error("no halt on halting op");
    property p_busy; flash_start_o && flash_op_o != FSPS_OP_LOCK && !run_halting |-> rww_read_block_o; endproperty
    a_busy: assert property (p_busy) else $error("section not blocked");
    property p_busy_rise; $rose(rww_read_block_o) |-> flash_start_o; endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy without operation");
    property p_busy_fall; $fell(rww_read_block_o) |-> $past(wb_we_i && wb_stb_i && wb_adr_i == FSPS_OFS_CTRL); endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy cleared without write");
    property p_page_hold; halt_o && $past(halt_o) |-> $stable(flash_page_o); endproperty
    a_page_hold: assert property (p_page_hold) else $error("page moved during op");
    property p_irq; flash_start_o |-> !irq_o; endproperty
    a_irq: assert property (p_irq) else $error("irq while enable set");
    property p_lock; (flash_lock_o & ~$past(flash_lock_o)) == 6'h00; endproperty
    a_lock: assert property (p_lock) else $error("lock bit unprogrammed");
    property p_ee; wb_ack_o && $past(!wb_we_i && wb_adr_i == FSPS_OFS_LOCK && eeprom_write_busy_i) |->
        wb_dat_o == 32'h0; endproperty
    a_ee: assert property (p_ee) else $error("lock read during eeprom write");
endmodule : fsps_sequencer_assertions

bind fsps_sequencer fsps_sequencer_assertions #(.PAGE_WORD_BITS(PAGE_WORD_BITS),
    .HALTING_WRITE_SECTION_FIRST_PAGE(HALTING_WRITE_SECTION_FIRST_PAGE)) chk_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .eeprom_write_busy_i(eeprom_write_busy_i),
    .flash_op_o(flash_op_o), .flash_start_o(flash_start_o), .flash_page_o(flash_page_o),
    .flash_lock_o(flash_lock_o), .halt_o(halt_o), .rww_read_block_o(rww_read_block_o), .irq_o(irq_o));

// ===== testbench/fsps_sequencer_test.sv
// self-checking bench of the flash self-programming sequencer
`timescale 1ns/1ns
module fsps_sequencer_test;
    import fsps_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ee = 1'b0, slow = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rd, wb_dat_o;
    logic [5:0] raddr = 6'h00, lock;
    logic [8:0] page;
    logic [15:0] buf_rdata_o, rword;
    logic wb_ack_o, start, done, halt, blk, irq;
    fsps_op_t op;
    int num_errors = 0, num_checks = 0, nstart = 0, n0;
    fsps_sequencer uut (.ref_clk_i(clk), .reset_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .eeprom_write_busy_i(ee), .flash_op_o(op), .flash_start_o(start), .flash_page_o(page),
        .flash_lock_o(lock), .flash_done_i(done), .buf_raddr_i(raddr), .buf_rdata_o(buf_rdata_o),
        .flash_rword_i(rword), .halt_o(halt), .rww_read_block_o(blk), .irq_o(irq));
    fsps_flash_model fm (.ref_clk_i(clk), .reset_i(rst), .flash_start_i(start), .slow_i(slow),
        .flash_done_o(done), .flash_rword_o(rword));
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (start === 1'b1) nstart <= nstart + 1; // started operations
    // ****
    // shared tasks
    // ****
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // classic cycle held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        #1;
    endtask : bus
    task automatic cmd(input logic [7:0] c); // control write then store strobe
        bus(1'b1, FSPS_OFS_CTRL, {24'h0, c});
        bus(1'b1, FSPS_OFS_STORE, 32'h0);
    endtask : cmd
    task automatic idle(); // poll until enable bit falls
        do begin
            bus(1'b0, FSPS_OFS_CTRL, 32'h0);
        end while (rd[0] !== 1'b0);
    endtask : idle
    task automatic bufchk(input logic [5:0] a, input logic [15:0] e); // one cycle read latency
        @(posedge clk) raddr <= a;
        repeat (2) @(posedge clk);
        #1 chk(buf_rdata_o, e);
    endtask : bufchk
    task automatic load(input logic [15:0] p, input logic [15:0] d);
        bus(1'b1, FSPS_OFS_PTR, p);
        bus(1'b1, FSPS_OFS_DATA, d);
        cmd(8'h01);
    endtask : load
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        bus(1'b0, FSPS_OFS_LOCK, 32'h0);
        chk(rd, 32'hff);
        bufchk(6'h00, 16'hffff);
        chk(blk, 1'b0);
        bus(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        $display("done reset");
    endtask : t_reset
    task automatic t_page();
        load(16'h000a, 16'h1111);
        load(16'h0004, 16'h2222);
        load(16'h0012, 16'h3333);
        bufchk(6'h05, 16'h1111);
        bufchk(6'h02, 16'h2222);
        slow = 1'b1;
        bus(1'b1, FSPS_OFS_PTR, 32'h0180);
        cmd(8'h05);
        chk({op, page, blk, halt}, {FSPS_OP_WRITE, 9'h003, 2'b10});
        bus(1'b1, FSPS_OFS_PTR, 32'hffff);
        chk(page, 9'h003);
        idle();
        bufchk(6'h05, 16'hffff);
        chk(blk, 1'b1);
        bus(1'b1, FSPS_OFS_CTRL, 32'h11);
        chk(blk, 1'b0);
        $display("done page");
    endtask : t_page
    task automatic t_erase();
        load(16'h0006, 16'h4444);
        bus(1'b1, FSPS_OFS_PTR, 32'h327f);
        cmd(8'h03);
        chk({op, page, blk, halt}, {FSPS_OP_ERASE, 9'h064, 2'b01});
        idle();
        chk(halt, 1'b0);
        bufchk(6'h03, 16'h4444);
        bus(1'b1, FSPS_OFS_CTRL, 32'h11);
        bufchk(6'h03, 16'hffff);
        $display("done erase");
    endtask : t_erase
    task automatic t_lock();
        bus(1'b1, FSPS_OFS_CTRL, 32'h80);
        chk(irq, 1'b1);
        bus(1'b1, FSPS_OFS_PTR, 32'h1234);
        bus(1'b1, FSPS_OFS_DATA, 32'hf6);
        cmd(8'h89);
        chk({op, halt, irq}, {FSPS_OP_LOCK, 2'b00});
        idle();
        chk(irq, 1'b1);
        bus(1'b0, FSPS_OFS_LOCK, 32'h0);
        chk(rd, 32'hf6);
        slow = 1'b0;
        bus(1'b1, FSPS_OFS_DATA, 32'hdf);
        cmd(8'h09);
        idle();
        bus(1'b0, FSPS_OFS_LOCK, 32'h0);
        chk(rd, 32'hd6);
        $display("done lock");
    endtask : t_lock
    task automatic t_window();
        n0 = nstart;
        bus(1'b1, FSPS_OFS_CTRL, 32'h03);
        repeat (8) @(posedge clk);
        bus(1'b1, FSPS_OFS_STORE, 32'h0);
        bus(1'b0, FSPS_OFS_CTRL, 32'h0);
        chk({nstart[25:0], rd[5:0]}, {n0[25:0], 6'h00});
        $display("done window");
    endtask : t_window
    task automatic t_eeprom();
        load(16'h000e, 16'h7777);
        @(posedge clk) ee <= 1'b1;
        bufchk(6'h07, 16'hffff);
        bus(1'b0, FSPS_OFS_LOCK, 32'h0);
        chk(rd, 32'h0);
        n0 = nstart;
        cmd(8'h03);
        repeat (4) @(posedge clk);
        chk(nstart, n0);
        @(posedge clk) ee <= 1'b0;
        bus(1'b1, FSPS_OFS_PTR, 32'h0001);
        bus(1'b0, FSPS_OFS_LOAD, 32'h0);
        chk(rd, 32'ha5);
        bus(1'b1, FSPS_OFS_PTR, 32'h0000);
        bus(1'b0, FSPS_OFS_LOAD, 32'h0);
        chk(rd, 32'h5a);
        $display("done eeprom");
    endtask : t_eeprom
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_page();
        t_erase();
        t_lock();
        t_window();
        t_eeprom();
        print_verdict();
    end
    // watchdog well past the expected run of under a thousand cycles
    initial begin
        #40000;
        num_errors++;
        print_verdict();
    end
endmodule : fsps_sequencer_test
